// File: output_driver_regs_pkg.sv
package output_driver_regs_pkg;

    // Register request from the control-port front end, on the same clock.
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // Pages that hold registers of this group.
    localparam logic [7:0] PAGE_VOLUME  = 8'h00;
    localparam logic [7:0] PAGE_DRIVERS = 8'h01;

    // Register offsets within a page; page select sits at offset zero of every page.
    localparam logic [7:0] OFS_PAGE_SELECT = 8'h00;
    localparam logic [7:0] OFS_VOLUME_CTRL = 8'h74;
    localparam logic [7:0] OFS_PIN_GAIN    = 8'h75;
    localparam logic [7:0] OFS_AMP_ERRCTL  = 8'h1E;
    localparam logic [7:0] OFS_HP_CTRL     = 8'h1F;
    localparam logic [7:0] OFS_SPK_CTRL    = 8'h20;

    // Reset values.
    localparam logic [7:0] RST_PAGE_SELECT = 8'h00;
    localparam logic [7:0] RST_VOLUME_CTRL = 8'h00;
    localparam logic [6:0] RST_PIN_GAIN    = 7'h00;
    localparam logic [7:0] RST_AMP_ERRCTL  = 8'h00;
    localparam logic [7:0] RST_HP_CTRL     = 8'h04;
    localparam logic [7:0] RST_SPK_CTRL    = 8'h06;

    // Field positions.
    localparam int BIT_VOL_FROM_PIN  = 7;
    localparam int BIT_SPK_KEEP      = 1;
    localparam int BIT_HP_KEEP       = 0;
    localparam int BIT_LEFT_PWR      = 7;
    localparam int BIT_RIGHT_PWR     = 6;
    localparam int BIT_CM_HI         = 4;
    localparam int BIT_CM_LO         = 3;
    localparam int BIT_HP_SHORT_PD   = 1;
    localparam int BIT_SHORT_STATUS  = 0;

    // Gain code that the converter may produce but that is never reported.
    localparam logic [6:0] GAIN_CODE_RESERVED = 7'h7F;
    // Gain code for 0 dB and for the start of the 1 dB steps.
    localparam logic [6:0] GAIN_CODE_ZERO_DB  = 7'h24;
    localparam logic [6:0] GAIN_CODE_COARSE   = 7'h5B;

endpackage

// File: output_driver_power_short_regs.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Page select is an 8-bit read-write value, reset to zero, choosing the page for later accesses.
// - Gain readback is 7 bits read-only; code 0 is +18 dB, each step -0.5 dB, 0 dB at code 0x24.
// - Past code 0x5A the readback steps 1 dB down to -63 dB at 0x7E; code 0x7F is never reported.
// - With the speaker keep bit clear, a speaker short clears both speaker power-up bits.
// - With the headphone keep bit clear and power-down response chosen, a short clears both bits.
// - Headphone register has read-write left and right power-up bits, both reset to zero.
// - On a headphone short the driver limits current when response is 0, powers down when 1.
// - Headphone short status reads 1 while a short is seen, else 0, and resets to zero.
// - Headphone common-mode select is a 2-bit field, 1.35 V to 1.8 V, reset to 00.
// - Speaker register has read-write left and right power-up bits, both reset to zero.
// - Speaker short status is live, non-latching and meaningful only while a driver is up.
// - Volume source bit 0 selects register volume and powers down the converter; 1 selects pin.
module output_driver_power_short_regs (
    // Clock and reset
    input  wire logic                              clock,
    input  wire logic                              resetn,
    // Register port from the control front end
    input  wire output_driver_regs_pkg::reg_req_s  regReq,
    output logic                      [7:0]        regRdata_r,
    // Volume converter result, same clock
    input  wire logic                              volValid,
    input  wire logic                 [6:0]        volCode,
    // Short detectors from the analog drivers, asynchronous
    input  wire logic                              hpShortPin,
    input  wire logic                              spkShortPin,
    // Driver controls
    output logic                                   leftHeadphoneDriverOn_r,
    output logic                                   rightHeadphoneDriverOn_r,
    output logic                                   leftSpeakerDriverOn_r,
    output logic                                   rightSpeakerDriverOn_r,
    output logic                      [1:0]        hpCommonMode_r,
    output logic                                   hpCurrentLimit_r,
    output logic                                   volFromPin_r,
    output logic                                   volConverterOn_r
);

    logic [7:0] pageSelect_r;
    logic [7:0] volumeCtrl_r;
    logic [6:0] pinGain_r;
    logic [7:0] ampErrCtl_r;
    logic [7:0] hpCtrl_r;
    logic [7:0] spkCtrl_r;
    logic       hpShortMeta_r;
    logic       hpShortSync_r;
    logic       spkShortMeta_r;
    logic       spkShortSync_r;
    logic [7:0] hpCtrl_nxt;
    logic [7:0] spkCtrl_nxt;
    logic [7:0] regRdata_nxt;

    function automatic logic hit(input logic [7:0] page, input logic [7:0] pg,
                                 input logic [7:0] addr, input logic [7:0] ofs);
        hit = (page == pg) && (addr == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Short detector synchronisers.

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            hpShortMeta_r  <= 1'b0;
            hpShortSync_r  <= 1'b0;
            spkShortMeta_r <= 1'b0;
            spkShortSync_r <= 1'b0;
        end else begin
            hpShortMeta_r  <= hpShortPin;
            hpShortSync_r  <= hpShortMeta_r;
            spkShortMeta_r <= spkShortPin;
            spkShortSync_r <= spkShortMeta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Page select and volume control.

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pageSelect_r <= output_driver_regs_pkg::RST_PAGE_SELECT;
        end else if (regReq.write && regReq.addr == output_driver_regs_pkg::OFS_PAGE_SELECT) begin
            pageSelect_r <= regReq.wdata;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            volumeCtrl_r <= output_driver_regs_pkg::RST_VOLUME_CTRL;
        end else if (regReq.write && hit(pageSelect_r, output_driver_regs_pkg::PAGE_VOLUME,
                                         regReq.addr, output_driver_regs_pkg::OFS_VOLUME_CTRL)) begin
            volumeCtrl_r <= regReq.wdata;
        end
    end

    // The reserved code is dropped so software never sees a gain that does not exist.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pinGain_r <= output_driver_regs_pkg::RST_PIN_GAIN;
        end else if (volValid && volumeCtrl_r[output_driver_regs_pkg::BIT_VOL_FROM_PIN]
                     && volCode != output_driver_regs_pkg::GAIN_CODE_RESERVED) begin
            pinGain_r <= volCode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Error control and driver registers.

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ampErrCtl_r <= output_driver_regs_pkg::RST_AMP_ERRCTL;
        end else if (regReq.write && hit(pageSelect_r, output_driver_regs_pkg::PAGE_DRIVERS,
                                         regReq.addr, output_driver_regs_pkg::OFS_AMP_ERRCTL)) begin
            ampErrCtl_r <= regReq.wdata;
        end
    end

    // A short is a level, so clearing after the write lets the detector win over a
    // power-up written during the fault.
    always_comb begin
        hpCtrl_nxt  = hpCtrl_r;
        spkCtrl_nxt = spkCtrl_r;
        if (regReq.write && hit(pageSelect_r, output_driver_regs_pkg::PAGE_DRIVERS,
                                regReq.addr, output_driver_regs_pkg::OFS_HP_CTRL)) begin
            hpCtrl_nxt = {regReq.wdata[7:1], 1'b0};
        end
        if (regReq.write && hit(pageSelect_r, output_driver_regs_pkg::PAGE_DRIVERS,
                                regReq.addr, output_driver_regs_pkg::OFS_SPK_CTRL)) begin
            spkCtrl_nxt = {regReq.wdata[7:1], 1'b0};
        end
        if (hpShortSync_r && !ampErrCtl_r[output_driver_regs_pkg::BIT_HP_KEEP]
            && hpCtrl_r[output_driver_regs_pkg::BIT_HP_SHORT_PD]) begin
            hpCtrl_nxt[output_driver_regs_pkg::BIT_LEFT_PWR]  = 1'b0;
            hpCtrl_nxt[output_driver_regs_pkg::BIT_RIGHT_PWR] = 1'b0;
        end
        if (spkShortSync_r && !ampErrCtl_r[output_driver_regs_pkg::BIT_SPK_KEEP]) begin
            spkCtrl_nxt[output_driver_regs_pkg::BIT_LEFT_PWR]  = 1'b0;
            spkCtrl_nxt[output_driver_regs_pkg::BIT_RIGHT_PWR] = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            hpCtrl_r  <= output_driver_regs_pkg::RST_HP_CTRL;
            spkCtrl_r <= output_driver_regs_pkg::RST_SPK_CTRL;
        end else begin
            hpCtrl_r  <= hpCtrl_nxt;
            spkCtrl_r <= spkCtrl_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Driver outputs.

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            leftHeadphoneDriverOn_r  <= 1'b0;
            rightHeadphoneDriverOn_r <= 1'b0;
            leftSpeakerDriverOn_r    <= 1'b0;
            rightSpeakerDriverOn_r   <= 1'b0;
            hpCommonMode_r           <= 2'h0;
            hpCurrentLimit_r         <= 1'b0;
            volFromPin_r             <= 1'b0;
            volConverterOn_r         <= 1'b0;
        end else begin
            // With the keep bit set the power-down response still removes drive.
            leftHeadphoneDriverOn_r  <= hpCtrl_r[output_driver_regs_pkg::BIT_LEFT_PWR]
                && !(hpShortSync_r && hpCtrl_r[output_driver_regs_pkg::BIT_HP_SHORT_PD]);
            rightHeadphoneDriverOn_r <= hpCtrl_r[output_driver_regs_pkg::BIT_RIGHT_PWR]
                && !(hpShortSync_r && hpCtrl_r[output_driver_regs_pkg::BIT_HP_SHORT_PD]);
            leftSpeakerDriverOn_r    <= spkCtrl_r[output_driver_regs_pkg::BIT_LEFT_PWR];
            rightSpeakerDriverOn_r   <= spkCtrl_r[output_driver_regs_pkg::BIT_RIGHT_PWR];
            hpCommonMode_r           <= hpCtrl_r[output_driver_regs_pkg::BIT_CM_HI:
                                                 output_driver_regs_pkg::BIT_CM_LO];
            hpCurrentLimit_r         <= hpShortSync_r
                && !hpCtrl_r[output_driver_regs_pkg::BIT_HP_SHORT_PD];
            volFromPin_r             <= volumeCtrl_r[output_driver_regs_pkg::BIT_VOL_FROM_PIN];
            volConverterOn_r         <= volumeCtrl_r[output_driver_regs_pkg::BIT_VOL_FROM_PIN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Read path. Reads touch only the data flop, so status reads have no side effect.

    always_comb begin
        regRdata_nxt = 8'h00;
        if (regReq.addr == output_driver_regs_pkg::OFS_PAGE_SELECT) begin
            regRdata_nxt = pageSelect_r;
        end else if (hit(pageSelect_r, output_driver_regs_pkg::PAGE_VOLUME, regReq.addr,
                         output_driver_regs_pkg::OFS_VOLUME_CTRL)) begin
            regRdata_nxt = volumeCtrl_r;
        end else if (hit(pageSelect_r, output_driver_regs_pkg::PAGE_VOLUME, regReq.addr,
                         output_driver_regs_pkg::OFS_PIN_GAIN)) begin
            regRdata_nxt = {1'b0, pinGain_r};
        end else if (hit(pageSelect_r, output_driver_regs_pkg::PAGE_DRIVERS, regReq.addr,
                         output_driver_regs_pkg::OFS_AMP_ERRCTL)) begin
            regRdata_nxt = ampErrCtl_r;
        end else if (hit(pageSelect_r, output_driver_regs_pkg::PAGE_DRIVERS, regReq.addr,
                         output_driver_regs_pkg::OFS_HP_CTRL)) begin
            regRdata_nxt = {hpCtrl_r[7:1], hpShortSync_r};
        end else if (hit(pageSelect_r, output_driver_regs_pkg::PAGE_DRIVERS, regReq.addr,
                         output_driver_regs_pkg::OFS_SPK_CTRL)) begin
            regRdata_nxt = {spkCtrl_r[7:1], spkShortSync_r};
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            regRdata_r <= 8'h00;
        end else if (regReq.read) begin
            regRdata_r <= regRdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    page_write_a: assert property (
        regReq.write && regReq.addr == output_driver_regs_pkg::OFS_PAGE_SELECT
        |=> pageSelect_r == $past(regReq.wdata))
        else $error("page select did not take the written value");

    gain_load_a: assert property (
        volValid && volumeCtrl_r[7] && volCode != output_driver_regs_pkg::GAIN_CODE_RESERVED
        |=> pinGain_r == $past(volCode))
        else $error("gain readback missed a converter result");

    gain_reserved_a: assert property (
        pinGain_r != output_driver_regs_pkg::GAIN_CODE_RESERVED)
        else $error("reserved gain code reported");

    spk_short_clear_a: assert property (
        spkShortSync_r && !ampErrCtl_r[1] ##1 1 |-> spkCtrl_r[7:6] == 2'b00 ##1
        !leftSpeakerDriverOn_r && !rightSpeakerDriverOn_r)
        else $error("speaker short did not clear power-up bits");

    hp_short_clear_a: assert property (
        hpShortSync_r && !ampErrCtl_r[0] && hpCtrl_r[1] |=> hpCtrl_r[7:6] == 2'b00)
        else $error("headphone short did not clear power-up bits");

    hp_limit_a: assert property (
        hpShortSync_r && !hpCtrl_r[1] |=> hpCurrentLimit_r)
        else $error("current limit not raised on headphone short");

    hp_status_a: assert property (
        regReq.read && regReq.addr == output_driver_regs_pkg::OFS_HP_CTRL
        && pageSelect_r == output_driver_regs_pkg::PAGE_DRIVERS
        |=> regRdata_r[0] == $past(hpShortSync_r))
        else $error("headphone status read wrong");

    common_mode_a: assert property (
        $stable(hpCtrl_r) [*2] |-> hpCommonMode_r == hpCtrl_r[4:3])
        else $error("common-mode output disagrees with field");

    read_no_effect_a: assert property (
        regReq.read && !regReq.write && !hpShortSync_r && !spkShortSync_r
        |=> $stable(hpCtrl_r) && $stable(spkCtrl_r) && $stable(ampErrCtl_r))
        else $error("a read changed register state");

    vol_converter_a: assert property (
        !volumeCtrl_r[7] ##1 !volumeCtrl_r[7] |-> !volConverterOn_r && !volFromPin_r)
        else $error("volume converter on while register volume selected");

    spk_status_a: assert property (
        regReq.read && regReq.addr == output_driver_regs_pkg::OFS_SPK_CTRL
        && pageSelect_r == output_driver_regs_pkg::PAGE_DRIVERS
        |=> regRdata_r[0] == $past(spkShortSync_r))
        else $error("speaker status read wrong");

    hp_powerdown_a: assert property (
        hpShortSync_r && hpCtrl_r[1]
        |=> !leftHeadphoneDriverOn_r && !rightHeadphoneDriverOn_r)
        else $error("headphone driver left on during a short with power-down response");

    hp_keep_a: assert property (
        !regReq.write && hpShortSync_r && ampErrCtl_r[0] |=> $stable(hpCtrl_r[7:6]))
        else $error("headphone power-up bits changed although kept");

    spk_keep_a: assert property (
        !regReq.write && ampErrCtl_r[1] |=> $stable(spkCtrl_r[7:6]))
        else $error("speaker power-up bits changed although kept");

    status_readonly_a: assert property (
        hpCtrl_r[0] == 1'b0 && spkCtrl_r[0] == 1'b0)
        else $error("a stored status bit was set by a write");

    spk_power_out_a: assert property (
        $stable(spkCtrl_r) |-> leftSpeakerDriverOn_r == spkCtrl_r[7]
        && rightSpeakerDriverOn_r == spkCtrl_r[6])
        else $error("speaker driver outputs disagree with power-up bits");

    hp_power_write_a: assert property (
        regReq.write && regReq.addr == output_driver_regs_pkg::OFS_HP_CTRL
        && pageSelect_r == output_driver_regs_pkg::PAGE_DRIVERS && !hpShortSync_r
        |=> hpCtrl_r[7:6] == $past(regReq.wdata[7:6]))
        else $error("headphone power-up bits did not take the written value");

    gain_hold_a: assert property (
        !volumeCtrl_r[7] |=> $stable(pinGain_r))
        else $error("gain readback moved while register volume selected");

endmodule

// File: host_model.sv
`timescale 1ns/100ps
module host_model (
    // Clock
    input  wire logic                              clock,
    // Register port toward the block
    output output_driver_regs_pkg::reg_req_s       regReq,
    input  wire logic                      [7:0]   regRdata_r
);
    logic [7:0] pageSeen;

    initial begin
        regReq   = '0;
        pageSeen = 8'h00;
    end

    // Reserved bits always leave with their prescribed values, whatever the caller asks for.
    function automatic logic [7:0] legal_data(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] d;
        d = data;
        if (pageSeen == 8'h01 && addr == 8'h1F) d = {d[7:6], 1'b0, d[4:3], 1'b1, d[1:0]};
        if (pageSeen == 8'h01 && addr == 8'h20) d = {d[7:6], 5'h03, d[0]};
        if (pageSeen == 8'h00 && addr == 8'h75) d[7] = 1'b0;
        return d;
    endfunction

    // Released lines show the inverse so that a stale value is never mistaken for a live one.
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clock);
        regReq.write = 1'b1;
        regReq.addr  = addr;
        regReq.wdata = legal_data(addr, data);
        if (addr == 8'h00) pageSeen = data;
        @(negedge clock);
        regReq.write = 1'b0;
        regReq.addr  = ~addr;
        regReq.wdata = ~regReq.wdata;
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clock);
        regReq.read = 1'b1;
        regReq.addr = addr;
        @(negedge clock);
        regReq.read = 1'b0;
        regReq.addr = ~addr;
        @(negedge clock);
        data = regRdata_r;
    endtask
endmodule

// File: output_driver_power_short_regs_bench.sv
`timescale 1ns/100ps
module output_driver_power_short_regs_bench;
    logic                             clock;
    logic                             resetn;
    logic                             volValid;
    logic                      [6:0]  volCode;
    logic                             hpShortPin;
    logic                             spkShortPin;
    output_driver_regs_pkg::reg_req_s regReq;
    logic                      [7:0]  regRdata_r;
    logic                             leftHp;
    logic                             rightHp;
    logic                             leftSpk;
    logic                             rightSpk;
    logic                      [1:0]  hpCm;
    logic                             hpLimit;
    logic                             volFromPin;
    logic                             volConvOn;
    int                               miscompares;
    int                               checksDone;
    int                               cycles;
    logic                      [6:0]  codes [5] = '{7'h00, 7'h24, 7'h5B, 7'h7E, 7'h7F};

    output_driver_power_short_regs dut (
        .clock(clock), .resetn(resetn), .regReq(regReq), .regRdata_r(regRdata_r),
        .volValid(volValid), .volCode(volCode), .hpShortPin(hpShortPin),
        .spkShortPin(spkShortPin), .leftHeadphoneDriverOn_r(leftHp),
        .rightHeadphoneDriverOn_r(rightHp), .leftSpeakerDriverOn_r(leftSpk),
        .rightSpeakerDriverOn_r(rightSpk), .hpCommonMode_r(hpCm),
        .hpCurrentLimit_r(hpLimit), .volFromPin_r(volFromPin), .volConverterOn_r(volConvOn)
    );

    host_model host (.clock(clock), .regReq(regReq), .regRdata_r(regRdata_r));

    always #10 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        checksDone++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        checksDone++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: output bit %b, expected %b", $time, got, exp);
        end
    endtask

    task automatic read_check(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        host.read_reg(addr, d);
        check_byte(d, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic pulse_vol(input logic [6:0] code);
        @(negedge clock);
        volValid = 1'b1;
        volCode  = code;
        @(negedge clock);
        volValid = 1'b0;
        volCode  = ~code;
    endtask

    // The whole run is under two hundred cycles; this only catches a hang.
    always @(posedge clock) begin
        cycles++;
        if (cycles > 20000) begin
            miscompares++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        resetn = 1'b0;
        volValid = 1'b0;
        volCode = 7'h00;
        hpShortPin = 1'b0;
        spkShortPin = 1'b0;
        miscompares = 0;
        checksDone = 0;
        cycles = 0;
        settle(4);
        resetn = 1'b1;
        check_bit(leftHp, 1'b0);
        read_check(8'h00, 8'h00);
        read_check(8'h74, 8'h00);
        read_check(8'h75, 8'h00);
        host.write_reg(8'h00, 8'hFF);
        read_check(8'h00, 8'hFF);
        read_check(8'h1F, 8'h00);
        host.write_reg(8'h00, 8'h01);
        read_check(8'h1E, 8'h00);
        read_check(8'h1F, 8'h04);
        read_check(8'h20, 8'h06);
        for (int cm = 0; cm < 4; cm++) begin
            host.write_reg(8'h1F, {2'b10, 1'b0, cm[1:0], 3'b100});
            settle(2);
            check_byte({6'h00, hpCm}, {6'h00, cm[1:0]});
        end
        check_bit(leftHp, 1'b1);
        check_bit(rightHp, 1'b0);
        read_check(8'h1F, 8'h9C);
        // Speaker short first with the power-up bits kept, then with them cleared.
        host.write_reg(8'h1E, 8'h02);
        host.write_reg(8'h20, 8'hC6);
        settle(2);
        check_bit(rightSpk, 1'b1);
        spkShortPin = 1'b1;
        settle(4);
        read_check(8'h20, 8'hC7);
        read_check(8'h20, 8'hC7);
        check_bit(leftSpk, 1'b1);
        host.write_reg(8'h1E, 8'h00);
        settle(4);
        check_bit(leftSpk, 1'b0);
        check_bit(rightSpk, 1'b0);
        spkShortPin = 1'b0;
        settle(4);
        read_check(8'h20, 8'h06);
        // Headphone short: current limit, then power-down with and without keeping the bits.
        host.write_reg(8'h1F, 8'hC4);
        hpShortPin = 1'b1;
        settle(4);
        check_bit(hpLimit, 1'b1);
        read_check(8'h1F, 8'hC5);
        host.write_reg(8'h1F, 8'hC6);
        settle(4);
        read_check(8'h1F, 8'h07);
        check_bit(hpLimit, 1'b0);
        host.write_reg(8'h1E, 8'h01);
        host.write_reg(8'h1F, 8'hC6);
        settle(4);
        read_check(8'h1F, 8'hC7);
        check_bit(leftHp, 1'b0);
        hpShortPin = 1'b0;
        settle(4);
        read_check(8'h1F, 8'hC6);
        // Gain readback follows the converter only while the pin source is chosen.
        host.write_reg(8'h00, 8'h00);
        pulse_vol(7'h10);
        read_check(8'h75, 8'h00);
        check_bit(volConvOn, 1'b0);
        host.write_reg(8'h74, 8'h80);
        settle(2);
        check_bit(volConvOn, 1'b1);
        check_bit(volFromPin, 1'b1);
        for (int i = 0; i < 5; i++) begin
            pulse_vol(codes[i]);
            read_check(8'h75, {1'b0, (codes[i] == 7'h7F) ? 7'h7E : codes[i]});
        end
        host.write_reg(8'h75, 8'h80);
        read_check(8'h75, 8'h7E);
        final_report();
    end
endmodule
